// file: verilog/irwc_pkg.sv
package irwc_pkg;
   // Array geometry
   localparam int unsigned ARRAY_DIM     = 2048;
   localparam int unsigned ADDR_W        = 11;
   localparam int unsigned START_W       = 10;
   localparam int unsigned DCREF_W       = 7;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_COL_START = 8'h04;
   localparam logic [7:0]  OFS_ROW_START = 8'h08;
   localparam logic [7:0]  OFS_DCREF_A   = 8'h0c;
   localparam logic [7:0]  OFS_DCREF_B   = 8'h10;
   localparam logic [7:0]  OFS_STATUS    = 8'h14;
   localparam logic [7:0]  OFS_COLPOS    = 8'h18;
   // Field positions
   localparam int unsigned CTRL_DUAL_BIT = 0;
   localparam int unsigned CTRL_AVG_BIT  = 1;
   localparam int unsigned STAT_ACT_BIT  = 16;
   localparam int unsigned STAT_AVG_BIT  = 17;
   localparam int unsigned STAT_DUAL_BIT = 18;
   // Reset values
   localparam logic [1:0]  CTRL_RST      = 2'h0;
   localparam logic [9:0]  START_RST     = 10'h000;
   localparam logic [6:0]  DCREF_RST     = 7'h7f;
   // Bus answers
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // Line sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_LINE = 2'b10
   } irwc_state_e;
endpackage : irwc_pkg

// file: verilog/irwc_readout.sv
`timescale 1ns/1ps
module irwc_readout
   import irwc_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 row_sync,
   input  wire logic                 col_sync,
   input  wire logic                 pix_tick,
   input  wire logic                 avg_pin,
   output logic                      pix_a_valid_q,
   output logic [ADDR_W-1:0]         pix_a_col_q,
   output logic                      pix_a_bus_q,
   output logic                      pix_b_valid_q,
   output logic [ADDR_W-1:0]         pix_b_col_q,
   output logic [ADDR_W-1:0]         pix_row_q,
   output logic                      avg_active_q,
   output logic [DCREF_W-1:0]        dc_ref_a_q,
   output logic [DCREF_W-1:0]        dc_ref_b_q
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   // Start register counts in pairs of lines
   function automatic logic [ADDR_W-1:0] start_addr(
      input logic [START_W-1:0] v);
      start_addr = {v, 1'b0};
   endfunction : start_addr

   // Columns consumed per pixel period
   function automatic logic [ADDR_W:0] col_step(input logic dual,
                                                input logic avg);
      col_step = {{(ADDR_W-2){1'b0}}, dual & avg, dual ^ avg, ~dual & ~avg};
   endfunction : col_step

   logic [1:0]          ctrl_q;
   logic [START_W-1:0]  col_start_q;
   logic [START_W-1:0]  row_start_q;
   irwc_state_e         st_q;
   logic                first_row_q;
   logic [ADDR_W-1:0]   col_q;
   logic                dual_w;
   logic                avg_w;
   logic [ADDR_W:0]     col_next;
   logic [ADDR_W:0]     col_b_w;
   logic                aw_hold_q;
   logic                w_hold_q;
   logic [7:0]          aw_addr_q;
   logic [31:0]         w_data_q;
   logic [3:0]          w_strb_q;
   logic                do_write;
   logic                wr_hit;
   logic [31:0]         rd_word;
   logic                rd_hit;

   assign dual_w   = ctrl_q[CTRL_DUAL_BIT];
   assign avg_w    = ctrl_q[CTRL_AVG_BIT] & avg_pin;
   assign col_next = {1'b0, col_q} + col_step(dual_w, avg_w);
   // Second output's column; past the array edge there is no sample
   assign col_b_w  = {1'b0, col_q} + (avg_w ? 12'h002 : 12'h001);

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end
      else
      begin
         s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (do_write)
            aw_hold_q <= 1'b0;
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (do_write)
            w_hold_q <= 1'b0;
      end
   end

   // Setup register offsets accept writes; others, status and column position included, answer with an error
   always_comb
   begin
      case (aw_addr_q)
         OFS_CTRL, OFS_COL_START, OFS_ROW_START,
         OFS_DCREF_A, OFS_DCREF_B: wr_hit = 1'b1;
         default:                  wr_hit = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Setup registers; only the low byte lanes carry fields
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q      <= CTRL_RST;
         col_start_q <= START_RST;
         row_start_q <= START_RST;
         dc_ref_a_q  <= DCREF_RST;
         dc_ref_b_q  <= DCREF_RST;
      end
      else if (do_write)
      begin
         case (aw_addr_q)
            OFS_CTRL:
               if (w_strb_q[0]) ctrl_q <= w_data_q[1:0];
            OFS_COL_START:
            begin
               if (w_strb_q[0]) col_start_q[7:0] <= w_data_q[7:0];
               if (w_strb_q[1]) col_start_q[9:8] <= w_data_q[9:8];
            end
            OFS_ROW_START:
            begin
               if (w_strb_q[0]) row_start_q[7:0] <= w_data_q[7:0];
               if (w_strb_q[1]) row_start_q[9:8] <= w_data_q[9:8];
            end
            OFS_DCREF_A:
               if (w_strb_q[0]) dc_ref_a_q <= w_data_q[6:0];
            OFS_DCREF_B:
               if (w_strb_q[0]) dc_ref_b_q <= w_data_q[6:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one-cycle decode, answer held until taken
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         OFS_CTRL:      rd_word[1:0] = ctrl_q;
         OFS_COL_START: rd_word[START_W-1:0] = col_start_q;
         OFS_ROW_START: rd_word[START_W-1:0] = row_start_q;
         OFS_DCREF_A:   rd_word[DCREF_W-1:0] = dc_ref_a_q;
         OFS_DCREF_B:   rd_word[DCREF_W-1:0] = dc_ref_b_q;
         OFS_STATUS:
         begin
            rd_word[ADDR_W-1:0]    = pix_row_q;
            rd_word[STAT_ACT_BIT]  = (st_q == ST_LINE);
            rd_word[STAT_AVG_BIT]  = avg_w;
            rd_word[STAT_DUAL_BIT] = dual_w;
         end
         OFS_COLPOS:    rd_word[ADDR_W-1:0] = col_q;
         default:       rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Row pointer: preset on row sync, advance on each later line
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pix_row_q   <= '0;
         first_row_q <= 1'b1;
      end
      else if (row_sync)
      begin
         pix_row_q   <= start_addr(row_start_q);
         first_row_q <= 1'b1;
      end
      else if (col_sync)
      begin
         first_row_q <= 1'b0;
         // Progressive order; last row holds rather than wrapping
         if (!first_row_q && pix_row_q != ADDR_W'(ARRAY_DIM - 1))
            pix_row_q <= pix_row_q + 1'b1;
      end
   end

   // Line sequencer; a column sync restarts any line in flight
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q  <= ST_IDLE;
         col_q <= '0;
      end
      else if (col_sync)
      begin
         st_q  <= ST_LINE;
         col_q <= start_addr(col_start_q);
      end
      else
      begin
         case (st_q)
            ST_IDLE: ;
            ST_LINE:
               if (pix_tick)
               begin
                  col_q <= col_next[ADDR_W-1:0];
                  // Line ends at the array edge
                  if (col_next[ADDR_W]) st_q <= ST_IDLE;
               end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Sample strobes; in dual mode the second output strobes with the first while its column is inside the array
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pix_a_valid_q <= 1'b0;
         pix_b_valid_q <= 1'b0;
         pix_a_col_q   <= '0;
         pix_b_col_q   <= '0;
         pix_a_bus_q   <= 1'b0;
         avg_active_q  <= 1'b0;
      end
      else
      begin
         avg_active_q  <= avg_w;
         pix_a_valid_q <= (st_q == ST_LINE) & pix_tick & ~col_sync;
         pix_b_valid_q <= (st_q == ST_LINE) & pix_tick & ~col_sync
                          & dual_w & ~col_b_w[ADDR_W];
         if ((st_q == ST_LINE) & pix_tick)
         begin
            pix_a_col_q <= col_q;
            // Single output without averaging alternates even and odd column buses
            pix_a_bus_q <= col_q[0] & ~dual_w;
            // Second output takes the neighbouring column or pair
            pix_b_col_q <= col_b_w[ADDR_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_col_preset: assert property (@(posedge clk) disable iff (rst)
      col_sync |=> col_q == {$past(col_start_q), 1'b0} && st_q == ST_LINE)
      else $error("column pointer not preset from start");
   a_row_preset: assert property (@(posedge clk) disable iff (rst)
      row_sync |=> pix_row_q == {$past(row_start_q), 1'b0})
      else $error("row pointer not preset from start");
   a_even_start: assert property (@(posedge clk) disable iff (rst)
      $past(col_sync) |-> col_q[0] == 1'b0)
      else $error("odd column start address");
   a_row_step: assert property (@(posedge clk) disable iff (rst)
      col_sync && !row_sync && !first_row_q && pix_row_q < 11'h7ff
      |=> pix_row_q == $past(pix_row_q) + 11'h001)
      else $error("row did not advance by one");
   a_col_step: assert property (@(posedge clk) disable iff (rst)
      st_q == ST_LINE && pix_tick && !col_sync && !avg_w && !dual_w
      && !col_next[ADDR_W] |=> col_q == $past(col_q) + 11'h001)
      else $error("single column step wrong");
   a_avg_gate: assert property (@(posedge clk) disable iff (rst)
      avg_active_q |-> $past(avg_pin) && $past(ctrl_q[CTRL_AVG_BIT]))
      else $error("averaging without pin and bit");
   a_dual_phase: assert property (@(posedge clk) disable iff (rst)
      pix_b_valid_q |-> pix_a_valid_q
      && pix_b_col_q > pix_a_col_q)
      else $error("second output out of phase");
   a_single_off: assert property (@(posedge clk) disable iff (rst)
      !$past(dual_w) |-> !pix_b_valid_q)
      else $error("second output active in single mode");
   a_dcref_hold: assert property (@(posedge clk) disable iff (rst)
      !$past(do_write) |-> $stable(dc_ref_a_q) && $stable(dc_ref_b_q))
      else $error("DC reference changed without write");
   a_bresp_wait: assert property (@(posedge clk) disable iff (rst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");

   c_line_done: cover property (@(posedge clk) disable iff (rst)
      st_q == ST_LINE ##1 st_q == ST_IDLE);
   c_dual_avg: cover property (@(posedge clk) disable iff (rst)
      pix_b_valid_q && avg_active_q);
   c_window: cover property (@(posedge clk) disable iff (rst)
      row_sync && row_start_q != 10'h000);
   c_bad_addr: cover property (@(posedge clk) disable iff (rst)
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule : irwc_readout

// file: sim/irwc_ctrl_model.sv
`timescale 1ns/1ps
// Camera controller model: frame and line syncs, pixel ticks, avg request
module irwc_ctrl_model
(
   input  wire logic clk,
   output logic      row_sync,
   output logic      col_sync,
   output logic      pix_tick,
   output logic      avg_pin
);
   // Overheads in 25 ns cycles: 5 us per frame, 200 ns per row
   localparam int FRAME_OVERHEAD_CYC = 200;
   localparam int ROW_OVERHEAD_CYC   = 8;

   // Idle levels from time zero
   initial
   begin
      row_sync = 1'b0;
      col_sync = 1'b0;
      pix_tick = 1'b0;
      avg_pin  = 1'b0;
   end

   // Frame start pulse, issued after start addresses are set
   task automatic frame();
      @(posedge clk);
      row_sync <= 1'b1;
      @(posedge clk);
      row_sync <= 1'b0;
      repeat (FRAME_OVERHEAD_CYC) @(posedge clk);
   endtask : frame

   // One line: sync then n ticks; slow spaces ticks out
   task automatic line(input int n, input bit slow);
      @(posedge clk);
      col_sync <= 1'b1;
      @(posedge clk);
      col_sync <= 1'b0;
      // Row overhead before the first pixel of the line
      repeat (ROW_OVERHEAD_CYC) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         pix_tick <= 1'b1;
         @(posedge clk);
         if (slow || i == n - 1)
         begin
            pix_tick <= 1'b0;
            if (slow)
               @(posedge clk);
         end
      end
   endtask : line

   // Averaging needs this pin besides the config bit
   task automatic set_avg(input logic v);
      @(posedge clk);
      avg_pin <= v;
   endtask : set_avg
endmodule : irwc_ctrl_model

// file: sim/image_readout_window_control_test.sv
`timescale 1ns/1ps
module image_readout_window_control_test
   import irwc_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0;
   logic [3:0]  wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic row_sync, col_sync, pix_tick, avg_pin;
   logic a_v, a_bus, b_v, avg_q;
   logic [10:0] a_col, b_col, row;
   logic [6:0]  dca, dcb;
   logic [34:0] smp_q[$];
   int error_cnt = 0, cmp_count = 0, cyc = 0;
   logic [31:0] rd;
   logic [1:0]  rs;

   // 25 ns clock
   always #12.5 clk = ~clk;

   irwc_readout i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .row_sync(row_sync),
      .col_sync(col_sync), .pix_tick(pix_tick), .avg_pin(avg_pin),
      .pix_a_valid_q(a_v), .pix_a_col_q(a_col), .pix_a_bus_q(a_bus),
      .pix_b_valid_q(b_v), .pix_b_col_q(b_col), .pix_row_q(row),
      .avg_active_q(avg_q), .dc_ref_a_q(dca), .dc_ref_b_q(dcb));

   irwc_ctrl_model i_ctrl (.clk(clk), .row_sync(row_sync),
      .col_sync(col_sync), .pix_tick(pix_tick), .avg_pin(avg_pin));

   // Sample capture; valid is high one cycle per sample, so look every edge
   always @(posedge clk)
      if (a_v === 1'b1)
         smp_q.push_back({a_bus, b_v, b_col, a_col, row});

   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         final_report();
      end
   end

   task automatic cmp(input logic [31:0] got, exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : cmp

   // Write: both channels offered together, each dropped when taken
   task automatic wr_s(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      cmp({30'h0, bresp}, {30'h0, er}, "bresp");
   endtask : wr_s

   // Full-word write
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      wr_s(a, d, 4'hf, er);
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rdr

   // Pop n samples of one line and judge column, pairing and row
   task automatic chk_line(input int n, input logic [10:0] c0, st, r,
                           input logic dual);
      logic [34:0] s;
      logic [10:0] c;
      repeat (3) @(posedge clk);
      cmp(smp_q.size(), n, "sample count");
      for (int i = 0; i < n && smp_q.size() > 0; i++)
      begin
         s = smp_q.pop_front();
         c = c0 + 11'(i) * st;
         cmp(s[21:11], c, "column a");
         cmp(s[10:0], r, "row");
         cmp(s[33], dual, "b in phase");
         if (dual) cmp(s[32:22], c + (st >> 1), "column b");
         cmp(s[34], dual ? 1'b0 : c[0], "bus mux");
      end
      smp_q.delete();
   endtask : chk_line

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      cmp(dca, 7'h7f, "dc ref a");
      cmp(dcb, 7'h7f, "dc ref b");
      cmp(avg_q, 1'b0, "avg off");
      rdr(OFS_DCREF_B);
      cmp(rd, 32'h7f, "dc ref read");
   endtask : t_reset

   task automatic t_bus_err();
      rdr(8'h1c);
      cmp({rs, rd}, {RESP_SLVERR, 32'h0}, "unmapped read");
      wr(OFS_STATUS, 32'hffff_ffff, RESP_SLVERR);
      wr(OFS_DCREF_A, 32'h05, RESP_OKAY);
      cmp(dca, 7'h05, "dc ref a write");
      wr(OFS_DCREF_B, 32'h40, RESP_OKAY);
      cmp(dcb, 7'h40, "dc ref b write");
   endtask : t_bus_err

   task automatic t_window();
      wr(OFS_COL_START, 32'h1, RESP_OKAY);
      wr(OFS_ROW_START, 32'h1, RESP_OKAY);
      i_ctrl.frame();
      i_ctrl.line(3, 1'b0);
      chk_line(3, 11'h2, 11'h1, 11'h2, 1'b0);
      i_ctrl.line(2, 1'b1);
      chk_line(2, 11'h2, 11'h1, 11'h3, 1'b0);
   endtask : t_window

   task automatic t_edge();
      wr(OFS_COL_START, 32'h3ff, RESP_OKAY);
      rdr(OFS_COL_START);
      cmp(rd, 32'h3ff, "ten bit start");
      // Low lane only: bits 9:8 keep their old zeros
      wr_s(OFS_ROW_START, 32'h3ff, 4'h1, RESP_OKAY);
      rdr(OFS_ROW_START);
      cmp(rd, 32'h0ff, "row start lane");
      i_ctrl.line(3, 1'b0);
      chk_line(2, 11'h7fe, 11'h1, 11'h4, 1'b0);
   endtask : t_edge

   task automatic t_dual_avg();
      wr(OFS_COL_START, 32'h2, RESP_OKAY);
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      i_ctrl.line(3, 1'b1);
      chk_line(3, 11'h4, 11'h2, 11'h5, 1'b1);
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp(avg_q, 1'b0, "bit alone");
      i_ctrl.set_avg(1'b1);
      repeat (3) @(posedge clk);
      cmp(avg_q, 1'b1, "pin and bit");
      i_ctrl.line(3, 1'b0);
      chk_line(3, 11'h4, 11'h2, 11'h6, 1'b0);
      wr(OFS_CTRL, 32'h3, RESP_OKAY);
      i_ctrl.line(2, 1'b1);
      chk_line(2, 11'h4, 11'h4, 11'h7, 1'b1);
      rdr(OFS_STATUS);
      cmp(rd, 32'h0007_0007, "status word");
      rdr(OFS_COLPOS);
      cmp(rd, 32'h0000_000c, "column position");
      rdr(OFS_CTRL);
      cmp(rd, 32'h3, "ctrl read");
   endtask : t_dual_avg

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_bus_err();
      t_window();
      t_edge();
      t_dual_avg();
      final_report();
   end
endmodule : image_readout_window_control_test
